/* File: fsp_top.sv */
// Purpose: Host-side status poller for a parallel NOR flash, run from AHB-Lite
// Assumes: Zero-wait slave; flash inputs synchronous to hclk
// Notes: Polls by data polling or toggle bits, issues reset on failure
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "fsp_consts.svh"
module fsp_top #(
  parameter int AW = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [AW-1:0] flash_addr,
  output logic [7:0] flash_dq_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic ready_busy_n
);
  fsp_cyc_if #(.AW(AW)) cyc();

  fsp_bus_cycle #(.AW(AW)) u_cyc (
    .hclk(hclk),
    .hresetn(hresetn),
    .cyc(cyc.exec),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_i(flash_dq_i),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );

  fsp_pkg::fsp_state_t st_q;
  fsp_pkg::fsp_mode_t mode_q;
  logic [AW-1:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] last_q;
  logic [7:0] prev_q;
  logic have_prev_q;
  logic dq5_seen_q;
  logic done_q;
  logic fail_q;
  logic tog2_q;
  logic timer_q;
  logic abort_q;
  logic ready_q;
  logic wr_pend_q;
  logic [7:0] wa_q;
  logic [31:0] rd_d;
  logic start_w;
  logic abort_w;
  logic ctrl_wr;
  logic busy;

  // AHB-Lite slave: address phase latched, write applied in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign busy = (st_q != fsp_pkg::ST_IDLE);
  assign ctrl_wr = wr_pend_q && (wa_q == `FSP_OFS_CTRL);
  assign start_w = ctrl_wr && hwdata[`FSP_CTRL_START] && !busy;
  assign abort_w = ctrl_wr && hwdata[`FSP_CTRL_ABORT] && busy;

  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      `FSP_OFS_CTRL: rd_d[`FSP_CTRL_MODE_HI:`FSP_CTRL_MODE_LO] = mode_q;
      `FSP_OFS_ADDR: rd_d[AW-1:0] = addr_q;
      `FSP_OFS_DATA: rd_d[7:0] = data_q;
      `FSP_OFS_STATUS: begin
        rd_d[`FSP_ST_BUSY] = busy;
        rd_d[`FSP_ST_DONE] = done_q;
        rd_d[`FSP_ST_FAIL] = fail_q;
        rd_d[`FSP_ST_TOG2] = tog2_q;
        rd_d[`FSP_ST_TIMER] = timer_q;
        rd_d[`FSP_ST_READY] = ready_q;
        rd_d[`FSP_ST_DQ5] = dq5_seen_q;
      end
      `FSP_OFS_RDATA: rd_d[7:0] = last_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // Target address frozen while polling so every status read hits it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
      data_q <= 8'h00;
    end else if (wr_pend_q && !busy) begin
      if (wa_q == `FSP_OFS_ADDR) begin
        addr_q <= hwdata[AW-1:0]; // RQ3 RQ5 RQ6
      end
      if (wa_q == `FSP_OFS_DATA) begin
        data_q <= hwdata[7:0];
      end
    end
  end

  // Open-drain pin level, pulled up outside; low means busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_busy_n;
    end
  end

  // Abort is honoured at the next status read answer in ST_WAIT, so no pin cycle is cut short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abort_q <= 1'b0;
    end else if (abort_w) begin
      abort_q <= 1'b1;
    end else if (!busy) begin
      abort_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= fsp_pkg::ST_IDLE;
      mode_q <= fsp_pkg::MD_DATA;
      last_q <= 8'h00;
      prev_q <= 8'h00;
      have_prev_q <= 1'b0;
      dq5_seen_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tog2_q <= 1'b0;
      timer_q <= 1'b0;
      cyc.req <= 1'b0;
      cyc.wr <= 1'b0;
      cyc.addr <= '0;
      cyc.wdata <= 8'h00;
    end else begin
      cyc.req <= 1'b0;
      case (st_q)
        fsp_pkg::ST_IDLE: begin
          if (start_w) begin
            // Every start begins the procedure afresh
            mode_q <= fsp_pkg::fsp_mode_t'(hwdata[`FSP_CTRL_MODE_HI:`FSP_CTRL_MODE_LO]);
            have_prev_q <= 1'b0; // RQ19
            dq5_seen_q <= 1'b0; // RQ19
            done_q <= 1'b0;
            fail_q <= 1'b0;
            tog2_q <= 1'b0;
            if (hwdata[`FSP_CTRL_MODE_HI]
                && !hwdata[`FSP_CTRL_MODE_LO]) begin
              st_q <= fsp_pkg::ST_RST;
            end else begin
              st_q <= fsp_pkg::ST_READ;
            end
          end
        end
        fsp_pkg::ST_READ, fsp_pkg::ST_LAST: begin
          cyc.req <= 1'b1;
          cyc.wr <= 1'b0;
          cyc.addr <= addr_q; // RQ3 RQ5
          st_q <= (st_q == fsp_pkg::ST_READ) ? fsp_pkg::ST_WAIT : fsp_pkg::ST_LWAIT;
        end
        fsp_pkg::ST_WAIT: begin
          if (cyc.done) begin
            last_q <= cyc.rdata;
            prev_q <= cyc.rdata;
            have_prev_q <= 1'b1;
            timer_q <= cyc.rdata[`FSP_DQ_TIMER];
            if (have_prev_q && (cyc.rdata[`FSP_DQ_TOG2] != prev_q[`FSP_DQ_TOG2])) begin
              tog2_q <= 1'b1;
            end
            if (abort_q) begin
              st_q <= fsp_pkg::ST_IDLE;
            end else if (mode_q == fsp_pkg::MD_READ) begin
              done_q <= 1'b1;
              st_q <= fsp_pkg::ST_IDLE;
            end else if (mode_q == fsp_pkg::MD_DATA) begin
              if (cyc.rdata[`FSP_DQ_POLL] == data_q[`FSP_DQ_POLL]) begin
                st_q <= fsp_pkg::ST_LAST; // RQ8
              end else if (dq5_seen_q) begin
                st_q <= fsp_pkg::ST_RST; // RQ9 RQ18
              end else begin
                dq5_seen_q <= cyc.rdata[`FSP_DQ_TOUT]; // RQ9
                st_q <= fsp_pkg::ST_READ;
              end
            end else begin
              if (!have_prev_q) begin
                st_q <= fsp_pkg::ST_READ; // RQ17
              end else if (cyc.rdata[`FSP_DQ_TOG1] == prev_q[`FSP_DQ_TOG1]) begin
                st_q <= fsp_pkg::ST_LAST; // RQ17
              end else if (dq5_seen_q) begin
                st_q <= fsp_pkg::ST_RST; // RQ18
              end else begin
                dq5_seen_q <= cyc.rdata[`FSP_DQ_TOUT]; // RQ18
                st_q <= fsp_pkg::ST_READ;
              end
            end
          end
        end
        fsp_pkg::ST_LWAIT: begin
          // Status bit may settle before the low bits; this read is the clean one
          if (cyc.done) begin
            last_q <= cyc.rdata; // RQ8
            done_q <= 1'b1;
            st_q <= fsp_pkg::ST_IDLE;
          end
        end
        fsp_pkg::ST_RST: begin
          cyc.req <= 1'b1;
          cyc.wr <= 1'b1;
          cyc.addr <= addr_q;
          cyc.wdata <= (mode_q == fsp_pkg::MD_WRITE) ? data_q : `FSP_CMD_RESET; // RQ18
          st_q <= fsp_pkg::ST_RWAIT;
        end
        fsp_pkg::ST_RWAIT: begin
          if (cyc.done) begin
            if (mode_q == fsp_pkg::MD_WRITE) begin
              done_q <= 1'b1;
            end else begin
              fail_q <= 1'b1; // RQ18
            end
            st_q <= fsp_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= fsp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RQ3_ADDR: assert property ((cyc.req && !cyc.wr && busy) |-> cyc.addr == addr_q) // RQ3
    else $error("status read not at target address");
  AST_RQ5_STABLE: assert property ((busy && $past(busy)) |-> $stable(addr_q)) // RQ5
    else $error("target address moved during polling");
  AST_RQ6_IGNORE: assert property ((wr_pend_q && wa_q == `FSP_OFS_ADDR && busy) |=> $stable(addr_q)) // RQ6
    else $error("address write taken while busy");
  AST_RQ8_FINAL: assert property (($rose(done_q) && !mode_q[1]) |-> $past(st_q) == fsp_pkg::ST_LWAIT) // RQ8
    else $error("poll finished without a follow-up read");
  AST_RQ9_RECHECK: assert property ($rose(fail_q) |-> dq5_seen_q && $past(dq5_seen_q, 2)) // RQ9
    else $error("failure declared without recheck after timeout bit");
  AST_RQ17_TWICE: assert property ((st_q == fsp_pkg::ST_WAIT && cyc.done && mode_q == fsp_pkg::MD_TOGGLE
      && have_prev_q && !abort_q && cyc.rdata[`FSP_DQ_TOG1] == prev_q[`FSP_DQ_TOG1])
      |=> st_q == fsp_pkg::ST_LAST ##1 (cyc.req && !cyc.wr)) // RQ17
    else $error("stable toggle bit not followed by data read");
  AST_RQ18_RESET: assert property ($rose(fail_q) |-> $past(st_q) == fsp_pkg::ST_RWAIT
      && cyc.wdata == `FSP_CMD_RESET && $past(cyc.wr)) // RQ18
    else $error("failure without reset command");
  AST_RQ19_RESTART: assert property (start_w |=> !have_prev_q && !dq5_seen_q && !done_q && !fail_q) // RQ19
    else $error("poll did not restart from first step");

  COV_DATA_OK: cover property ($rose(done_q) && mode_q == fsp_pkg::MD_DATA);
  COV_TOGGLE_OK: cover property ($rose(done_q) && mode_q == fsp_pkg::MD_TOGGLE);
  COV_FAIL: cover property ($rose(fail_q));
  COV_TOG2: cover property ($rose(tog2_q));
endmodule // fsp_top
`default_nettype wire

/* File: fsp_consts.svh */
// Purpose: Shared constants for the flash status poller
// Assumes: Included by its bare name
// Notes: Byte-wide flash data; own register map on AHB-Lite
//
// Contract
// [RQ1] Device makes the polling bit valid from the last write strobe rising edge.
// [RQ2] Device drives inverse of written bit 7 while programming, true bit when done.
// [RQ3] Host reads status at the program address; protected target shows short busy.
// [RQ4] Device drives 0 on polling bit during erase, 1 when done or suspended.
// [RQ5] Host polls erase status at an address inside a chosen sector.
// [RQ6] Host may use any unprotected sector address during chip erase.
// [RQ7] All chosen sectors protected gives about 100 us busy, else protected ones skipped.
// [RQ8] Host takes valid data only from the read after polling bit turns true.
// [RQ9] Host rechecks the polling bit after timeout failure bit reads 1.
// [RQ10] Device ready/busy pin is open drain, valid from last write strobe.
// [RQ11] Device pulls ready/busy low while busy, releases it when reads possible.
// [RQ12] Device inverts toggle bit one on every read while an operation runs.
// [RQ13] Toggle bit one valid from last write strobe and during erase timeout.
// [RQ14] Protected targets toggle bit one about 100 us or 1 us, then array reads.
// [RQ15] Toggle bit one stops in erase suspend, toggles during suspend program.
// [RQ16] Toggle bit two toggles on reads inside chosen erase sectors.
// [RQ17] Host reads twice and compares toggle bit; unchanged means done.
// [RQ18] Still toggling: check timeout bit, recheck, then failure needs reset command.
// [RQ19] Host restarts the status procedure from its first step after leaving it.
// [RQ20] Device sets timeout failure bit when pulse-count limit is exceeded.
// [RQ21] Erase timer bit reads 0 during sector timeout window, 1 once erase begins.
// [RQ22] Device counts each completed read strobe as one read cycle for toggling.
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

`define FSP_OFS_CTRL 8'h00
`define FSP_OFS_ADDR 8'h04
`define FSP_OFS_DATA 8'h08
`define FSP_OFS_STATUS 8'h0c
`define FSP_OFS_RDATA 8'h10

`define FSP_CTRL_START 0
`define FSP_CTRL_MODE_LO 1
`define FSP_CTRL_MODE_HI 2
`define FSP_CTRL_ABORT 3

`define FSP_ST_BUSY 0
`define FSP_ST_DONE 1
`define FSP_ST_FAIL 2
`define FSP_ST_TOG2 3
`define FSP_ST_TIMER 4
`define FSP_ST_READY 5
`define FSP_ST_DQ5 6

`define FSP_DQ_POLL 7
`define FSP_DQ_TOG1 6
`define FSP_DQ_TOUT 5
`define FSP_DQ_TIMER 3
`define FSP_DQ_TOG2 2

`define FSP_CMD_RESET 8'hf0
`define FSP_DW 8

`define FSP_SETUP_CYC 2
`define FSP_STROBE_CYC 14
`define FSP_HOLD_CYC 4

`endif

/* File: fsp_pkg.sv */
// Purpose: Types for the flash status poller
// Assumes: Nothing imported by users
// Notes: Gray codes along the usual poll path
`default_nettype none
package fsp_pkg;
  typedef enum logic [1:0] {
    MD_DATA = 2'h0,
    MD_TOGGLE = 2'h1,
    MD_WRITE = 2'h2,
    MD_READ = 2'h3
  } fsp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_WAIT = 3'h3,
    ST_LAST = 3'h2,
    ST_LWAIT = 3'h6,
    ST_RST = 3'h7,
    ST_RWAIT = 3'h5
  } fsp_state_t;

  typedef enum logic [1:0] {
    CY_IDLE = 2'h0,
    CY_SETUP = 2'h1,
    CY_STROBE = 2'h3,
    CY_HOLD = 2'h2
  } fsp_cyc_state_t;
endpackage
`default_nettype wire

/* File: fsp_cyc_if.sv */
// Purpose: One flash bus cycle request and its answer
// Assumes: req is a one-cycle pulse, done a one-cycle pulse
// Notes: rdata is valid with done on reads
`timescale 1ns/10ps
`default_nettype none
interface fsp_cyc_if #(parameter int AW = 20);
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctrl(output req, output wr, output addr, output wdata, input done, input rdata);
  modport exec(input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

/* File: fsp_bus_cycle.sv */
// Purpose: Drives one asynchronous flash read or write cycle on the pins
// Assumes: Flash timing met by the cycle counts at 200 MHz
// Notes: Data bus enable is active low while driving
`timescale 1ns/10ps
`default_nettype none
`include "fsp_consts.svh"
module fsp_bus_cycle #(
  parameter int AW = 20,
  parameter int SETUP = `FSP_SETUP_CYC,
  parameter int STROBE = `FSP_STROBE_CYC,
  parameter int HOLD = `FSP_HOLD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  fsp_cyc_if.exec cyc,
  output logic [AW-1:0] flash_addr,
  output logic [7:0] flash_dq_o,
  input wire logic [7:0] flash_dq_i,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  localparam logic [7:0] SETUP_C = 8'(SETUP - 1);
  localparam logic [7:0] STROBE_C = 8'(STROBE - 1);
  localparam logic [7:0] HOLD_C = 8'(HOLD - 1);

  fsp_pkg::fsp_cyc_state_t st_q;
  logic [7:0] cnt_q;
  logic wr_q;

  // Each completed read strobe (flash_oe_n) is one read cycle to the flash
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= fsp_pkg::CY_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      flash_addr <= '0;
      flash_dq_o <= 8'h00;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      case (st_q)
        fsp_pkg::CY_IDLE: begin
          if (cyc.req) begin
            wr_q <= cyc.wr;
            flash_addr <= cyc.addr;
            flash_dq_o <= cyc.wdata;
            flash_dq_oe_n <= ~cyc.wr;
            flash_ce_n <= 1'b0;
            cnt_q <= SETUP_C;
            st_q <= fsp_pkg::CY_SETUP;
          end
        end
        fsp_pkg::CY_SETUP: begin
          if (cnt_q == 8'h00) begin
            flash_we_n <= ~wr_q;
            flash_oe_n <= wr_q;
            cnt_q <= STROBE_C;
            st_q <= fsp_pkg::CY_STROBE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        fsp_pkg::CY_STROBE: begin
          if (cnt_q == 8'h00) begin
            if (!wr_q) begin
              cyc.rdata <= flash_dq_i;
            end
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt_q <= HOLD_C;
            st_q <= fsp_pkg::CY_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        fsp_pkg::CY_HOLD: begin
          if (cnt_q == 8'h00) begin
            // Data held past the write strobe rising edge, where it latches
            flash_ce_n <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            cyc.done <= 1'b1;
            st_q <= fsp_pkg::CY_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          st_q <= fsp_pkg::CY_IDLE;
        end
      endcase
    end
  end
endmodule // fsp_bus_cycle
`default_nettype wire

/* File: fsp_flash_model.sv */
// Purpose: Behavioural byte-wide flash that reports embedded program/erase status
// Assumes: Any host write other than the reset command is the final write of a command
// Notes: The bench picks the operation kind; the number of reads stands in for algorithm time
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_model #(
  parameter int PRG_PROT_NS = 1000,
  parameter int ERS_PROT_NS = 100000
) (
  input wire logic [19:0] addr,
  input wire logic [7:0] dq_in,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [1:0] op_kind,
  input wire logic prot,
  input wire logic fail_en,
  input wire logic [7:0] busy_reads,
  input wire logic [7:0] old_val,
  output logic [7:0] dq_out,
  output logic rb_oe_n,
  output int reset_count
);
  logic busy = 1'b0;
  logic susp = 1'b0;
  logic fail = 1'b0;
  logic tog1 = 1'b0;
  logic tog2 = 1'b0;
  logic timer = 1'b0;
  logic [7:0] datum = 8'h00;
  logic [7:0] arr = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  int reads = 0;
  initial reset_count = 0;
  always @(posedge we_n) begin
    if (!ce_n) begin
      if (dq_in == 8'hf0) begin
        busy = 1'b0;
        susp = 1'b0;
        fail = 1'b0;
        reset_count++;
      end else begin
        busy = 1'b1;
        susp = 1'b0;
        fail = 1'b0;
        timer = 1'b0;
        reads = 0;
        datum = dq_in;
        arr = old_val;
        if (prot) begin
          // Protected target: short busy, array left untouched
          #((op_kind == 2'd0) ? PRG_PROT_NS : ERS_PROT_NS);
          busy = 1'b0;
        end
      end
    end
  end
  always @(posedge oe_n) begin
    if (!ce_n) begin
      last = val;
      if (busy) tog1 = ~tog1;
      if ((busy || susp) && op_kind != 2'd0) tog2 = ~tog2;
      if (busy) timer = 1'b1;
      reads++;
      if (busy && !prot && !fail && reads >= busy_reads) begin
        if (fail_en) begin
          fail = 1'b1;
        end else if (op_kind == 2'd2) begin
          busy = 1'b0;
          susp = 1'b1;
        end else begin
          busy = 1'b0;
          arr = (op_kind == 2'd0) ? datum : 8'hff;
        end
      end
    end
  end
  always @* begin
    val = arr;
    if (busy || susp) begin
      val = 8'(reads * 37);
      val[7] = susp ? 1'b1 : ((op_kind == 2'd0) ? ~datum[7] : 1'b0);
      val[6] = tog1;
      val[5] = fail;
      val[3] = (op_kind != 2'd0) & timer;
      val[2] = (op_kind != 2'd0) & tog2;
    end
    // A released bus must not look like it still holds the last byte
    dq_out = (!ce_n && !oe_n) ? val : ~last;
  end
  assign rb_oe_n = !busy;
endmodule // fsp_flash_model
`default_nettype wire

/* File: test_flash_write_status_reporting.sv */
// Purpose: Self-checking bench for the flash status poller against a flash model
// Assumes: Zero-wait AHB-Lite slave; open-drain ready pin with a pull-up
// Notes: Every operation kind runs under both data polling and toggle polling
`timescale 1ns/10ps
`default_nettype none
`include "fsp_consts.svh"
module test_flash_write_status_reporting;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [19:0] flash_addr;
  logic [7:0] flash_dq_o, flash_dq_i, m_dq, m_reads, m_old;
  logic flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n, ready_busy_n, rb_oe_n, m_prot, m_fail;
  logic [1:0] m_kind;
  int m_resets, err_count, comparisons;
  logic [19:0] tgt;
  fsp_top #(.AW(20)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
    .flash_dq_i(flash_dq_i), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .ready_busy_n(ready_busy_n));
  fsp_flash_model u_flash (.addr(flash_addr), .dq_in(flash_dq_o), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .op_kind(m_kind), .prot(m_prot), .fail_en(m_fail), .busy_reads(m_reads),
    .old_val(m_old), .dq_out(m_dq), .rb_oe_n(rb_oe_n), .reset_count(m_resets));
  assign flash_dq_i = !flash_dq_oe_n ? flash_dq_o : m_dq;
  assign ready_busy_n = rb_oe_n ? 1'b1 : 1'b0;
  // Every flash cycle, status read or command write, must land on the target address
  always @(negedge flash_oe_n or negedge flash_we_n) chk({12'h000, flash_addr}, {12'h000, tgt});

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 0);
  endtask
  task automatic wait_idle(output logic [31:0] st);
    int n;
    n = 0;
    repeat (2) @(posedge hclk);
    do begin
      ahb(1'b0, `FSP_OFS_STATUS, 32'h0, st);
      n++;
    end while (st[`FSP_ST_BUSY] !== 1'b0 && n < 10000);
    // A poll that never ends counts as a mismatch here
    chk(st[`FSP_ST_BUSY], 0);
  endtask
  // kind: 0 program, 1 erase, 2 erase then suspend, 3 program that times out
  task automatic run(input int kind, input logic pr, input int mode);
    logic [31:0] rd, st;
    logic [7:0] d, old, expd;
    int prev;
    d = 8'($urandom);
    old = 8'($urandom);
    prev = m_resets;
    @(posedge hclk);
    m_kind <= (kind == 3) ? 2'd0 : 2'(kind);
    m_fail <= (kind == 3);
    m_prot <= pr;
    m_reads <= 8'(1 + $urandom % 6);
    m_old <= old;
    tgt = 20'($urandom);
    ahb(1'b1, `FSP_OFS_ADDR, {12'h000, tgt}, rd);
    ahb(1'b1, `FSP_OFS_DATA, {24'h0, d}, rd);
    ahb(1'b1, `FSP_OFS_CTRL, 32'h5, rd);
    wait_idle(st);
    ahb(1'b0, `FSP_OFS_STATUS, 32'h0, rd);
    chk(rd[`FSP_ST_READY], 0);
    expd = (kind == 0 || kind == 3) ? d : 8'hff;
    ahb(1'b1, `FSP_OFS_DATA, {24'h0, expd}, rd);
    ahb(1'b1, `FSP_OFS_CTRL, 32'(1 | (mode << 1)), rd);
    wait_idle(st);
    chk(st[2:0], (kind == 3) ? 3'b100 : 3'b010);
    chk(st[`FSP_ST_DQ5], kind == 3);
    chk(st[`FSP_ST_READY], 1);
    ahb(1'b0, `FSP_OFS_RDATA, 32'h0, rd);
    if (kind == 2) chk(rd[7], 1);
    else if (kind != 3) chk(rd[7:0], pr ? old : expd);
    if (kind == 3) chk(m_resets, prev + 1);
    if ((kind == 1 || kind == 2) && !pr) chk(st[`FSP_ST_TIMER], 1);
    if (kind == 0) begin
      ahb(1'b1, `FSP_OFS_CTRL, 32'h7, rd);
      wait_idle(st);
      chk(st[2:0], 3'b010);
      ahb(1'b0, `FSP_OFS_CTRL, 32'h0, rd);
      chk(rd & 32'h6, 32'h6);
      ahb(1'b0, `FSP_OFS_RDATA, 32'h0, rd);
      chk(rd[7:0], pr ? old : expd);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    #250000;
    err_count++;
    report_and_stop();
  end
  initial begin
    logic [31:0] rd;
    err_count = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    m_kind = 2'd0;
    m_prot = 1'b0;
    m_fail = 1'b0;
    m_reads = 8'h01;
    m_old = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(93));
    ahb(1'b0, `FSP_OFS_STATUS, 32'h0, rd);
    chk(rd & 32'h7f, 32'h20);
    ahb(1'b0, `FSP_OFS_CTRL, 32'h0, rd);
    chk(rd & 32'h6, 32'h0);
    ahb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
    for (int k = 0; k < 4; k++) begin
      for (int m = 0; m < 2; m++) run(k, 1'b0, m);
    end
    // Abort a toggle poll while the flash stays busy; it must stop with neither done nor fail
    @(posedge hclk);
    m_fail <= 1'b0;
    m_reads <= 8'hc8;
    ahb(1'b1, `FSP_OFS_CTRL, 32'h5, rd);
    wait_idle(rd);
    ahb(1'b1, `FSP_OFS_CTRL, 32'h3, rd);
    ahb(1'b1, `FSP_OFS_CTRL, 32'h8, rd);
    wait_idle(rd);
    chk(rd[2:0], 3'b000);
    run(0, 1'b1, 1);
    run(1, 1'b1, 1);
    report_and_stop();
  end
endmodule // test_flash_write_status_reporting
`default_nettype wire
